// file: uoec_pkg.sv
package uoec_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] CTL_LO_IDX  = 10'h014;
  localparam logic [9:0] CTL_HI_IDX  = 10'h015;
  localparam logic [9:0] INT_STS_IDX = 10'h016;
  localparam logic [9:0] INT_CLR_IDX = 10'h017;
  localparam logic [9:0] INT_EN_IDX  = 10'h018;

  // Low control byte fields
  localparam int LO_TGL_CLR  = 7;
  localparam int LO_STL_SENT = 6;
  localparam int LO_STL_REQ  = 5;
  localparam int LO_FLUSH    = 4;
  localparam int LO_CRC_ERR  = 3;
  localparam int LO_OVERRUN  = 2;
  localparam int LO_FULL     = 1;
  localparam int LO_PKT_RDY  = 0;

  // High control byte fields
  localparam int HI_DBL = 7;
  localparam int HI_ISO = 6;

  // Interrupt status, clear and enable layout
  localparam int INT_PKT = 0;
  localparam int INT_STL = 1;
  localparam int INT_OVR = 2;

  // Reset values and buffer capacities in packets
  localparam logic [7:0] CTL_LO_RST = 8'h00;
  localparam logic [7:0] CTL_HI_RST = 8'h00;
  localparam logic [2:0] INT_EN_RST = 3'h0;
  localparam logic [1:0] CAP_SINGLE = 2'h1;
  localparam logic [1:0] CAP_DOUBLE = 2'h2;

  // Events from the serial engine, same clock
  typedef struct packed {
    logic token;      // OUT token seen
    logic data_done;  // OUT data packet ended
    logic crc_err;    // That packet failed its CRC
  } uoec_rx_t;

  // Answers to the serial engine
  typedef struct packed {
    logic stall_hs;   // Send a stall handshake, one cycle
    logic room;       // FIFO can take a packet
    logic toggle;     // Expected data toggle
  } uoec_tx_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uoec_apb_req_t;

  typedef struct packed {
    logic        stall_req;
    logic        stall_sent;
    logic        crc_err;
    logic        overrun;
    logic        pkt_rdy;
    logic        dbl;
    logic        iso;
    logic [1:0]  pkts;
    logic        toggle;
    logic        stall_hs;
    logic [2:0]  int_sts;
    logic [2:0]  int_en;
    logic [31:0] prdata;
  } uoec_state_t;
endpackage

// file: uoec_out_ep.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// RULE1 - Transmitting a stall handshake sets the sent-stall flag.
// RULE2 - Firmware alone clears the sent-stall flag by writing zero.
// RULE3 - Double-buffer bit one gives two packet slots, zero gives one.
// RULE4 - Transfer-type bit one means isochronous, zero means bulk or interrupt.
// RULE5 - High byte bits five to zero read zero and ignore writes.
// RULE6 - Bulk packet received sets packet-ready and raises an endpoint interrupt.
// RULE7 - While stall request is set, every OUT is answered with stall.
// RULE8 - Isochronous packet with no room is dropped, sets overrun, interrupts.
// RULE9 - Isochronous CRC-failed packet is stored, sets packet-ready and data error.
// RULE10 - Writing one to toggle-clear zeroes the data toggle; bit reads zero.
module uoec_out_ep (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire uoec_pkg::uoec_apb_req_t apb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire uoec_pkg::uoec_rx_t     rx,
  output uoec_pkg::uoec_tx_t          tx,
  output logic                        irq
);
  uoec_pkg::uoec_state_t st_r;
  uoec_pkg::uoec_state_t st_nxt;
  logic [9:0] idx;
  logic       hit;
  logic       wr;
  logic       wr_lo;
  logic [1:0] cap;
  logic       full;
  logic [2:0] ev;

  // Zero wait states; a low clock enable stretches the access phase
  assign pready  = ce;
  assign idx     = apb.paddr[11:2];
  assign hit     = (idx == uoec_pkg::CTL_LO_IDX) || (idx == uoec_pkg::CTL_HI_IDX) ||
                   (idx == uoec_pkg::INT_STS_IDX) || (idx == uoec_pkg::INT_CLR_IDX) ||
                   (idx == uoec_pkg::INT_EN_IDX);
  assign pslverr = apb.psel && apb.penable && !hit;
  assign wr      = apb.psel && apb.penable && apb.pwrite && ce && hit;
  assign wr_lo   = wr && (idx == uoec_pkg::CTL_LO_IDX);
  assign cap     = st_r.dbl ? uoec_pkg::CAP_DOUBLE : uoec_pkg::CAP_SINGLE;  // [RULE3]
  assign full    = (st_r.pkts >= cap);

  // Outputs straight from state flops
  assign prdata      = st_r.prdata;
  assign tx.stall_hs = st_r.stall_hs;
  assign tx.room     = !full;
  assign tx.toggle   = st_r.toggle;
  assign irq         = |(st_r.int_sts & st_r.int_en);

  // Next state: software effects first, hardware events last so a set wins
  always_comb begin
    st_nxt          = st_r;
    ev              = 3'h0;
    st_nxt.stall_hs = 1'b0;
    if (wr_lo) begin
      if (apb.pwdata[uoec_pkg::LO_TGL_CLR]) begin
        st_nxt.toggle = 1'b0;  // [RULE10]
      end
      st_nxt.stall_req = apb.pwdata[uoec_pkg::LO_STL_REQ];
      if (!apb.pwdata[uoec_pkg::LO_STL_SENT]) begin
        st_nxt.stall_sent = 1'b0;  // [RULE2]
      end
      if (!apb.pwdata[uoec_pkg::LO_OVERRUN]) begin
        st_nxt.overrun = 1'b0;
      end
      // Unload or flush drops the oldest packet; a second one is re-announced
      if (((st_r.pkt_rdy && !apb.pwdata[uoec_pkg::LO_PKT_RDY]) ||
           apb.pwdata[uoec_pkg::LO_FLUSH]) && (st_r.pkts != 2'h0)) begin
        st_nxt.pkts    = st_r.pkts - 2'h1;
        st_nxt.crc_err = 1'b0;
        st_nxt.pkt_rdy = (st_nxt.pkts != 2'h0);
        ev[uoec_pkg::INT_PKT] = st_nxt.pkt_rdy;
      end
    end
    // High byte keeps only the two mode bits; the rest read zero
    if (wr && (idx == uoec_pkg::CTL_HI_IDX)) begin
      st_nxt.dbl = apb.pwdata[uoec_pkg::HI_DBL];  // [RULE3]
      st_nxt.iso = apb.pwdata[uoec_pkg::HI_ISO];  // [RULE4]
    end
    // Enable is plain read-write; the clear register is write-one-to-clear
    if (wr && (idx == uoec_pkg::INT_EN_IDX)) begin
      st_nxt.int_en = apb.pwdata[2:0];
    end
    if (wr && (idx == uoec_pkg::INT_CLR_IDX)) begin
      st_nxt.int_sts = st_r.int_sts & ~apb.pwdata[2:0];
    end
    // Stalled endpoint: answer the token, take no data
    if (rx.token && st_r.stall_req) begin
      st_nxt.stall_hs       = 1'b1;  // [RULE7]
      st_nxt.stall_sent     = 1'b1;  // [RULE1]
      ev[uoec_pkg::INT_STL] = 1'b1;
    end
    if (rx.data_done && !st_r.stall_req) begin  // [RULE7]
      if (st_r.iso) begin  // [RULE4]
        if (st_nxt.pkts < cap) begin
          st_nxt.pkts           = st_nxt.pkts + 2'h1;
          st_nxt.pkt_rdy        = 1'b1;  // [RULE9]
          ev[uoec_pkg::INT_PKT] = 1'b1;
          if (rx.crc_err) begin
            st_nxt.crc_err = 1'b1;  // [RULE9]
          end
        end else begin
          st_nxt.overrun        = 1'b1;  // [RULE8]
          ev[uoec_pkg::INT_OVR] = 1'b1;
        end
      end else if (!rx.crc_err && (st_nxt.pkts < cap)) begin
        // Bulk with CRC error or no room is left to the engine to ignore or NAK
        st_nxt.pkts           = st_nxt.pkts + 2'h1;
        st_nxt.pkt_rdy        = 1'b1;  // [RULE6]
        st_nxt.toggle         = !st_nxt.toggle;
        ev[uoec_pkg::INT_PKT] = 1'b1;  // [RULE6]
      end
    end
    st_nxt.int_sts = st_nxt.int_sts | ev;
    // Read data captured in the setup phase, held for the access phase
    if (apb.psel && !apb.penable) begin
      unique case (idx)
        uoec_pkg::CTL_LO_IDX:
          st_nxt.prdata = {24'h0, 1'b0, st_r.stall_sent, st_r.stall_req, 1'b0,
                           st_r.crc_err, st_r.overrun, full, st_r.pkt_rdy};  // [RULE10]
        uoec_pkg::CTL_HI_IDX:
          st_nxt.prdata = {24'h0, st_r.dbl, st_r.iso, 6'h00};  // [RULE5]
        uoec_pkg::INT_STS_IDX:
          st_nxt.prdata = {29'h0, st_r.int_sts};
        uoec_pkg::INT_EN_IDX:
          st_nxt.prdata = {29'h0, st_r.int_en};
        default:
          st_nxt.prdata = 32'h0;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r            <= '0;
      st_r.stall_req  <= uoec_pkg::CTL_LO_RST[uoec_pkg::LO_STL_REQ];
      st_r.dbl        <= uoec_pkg::CTL_HI_RST[uoec_pkg::HI_DBL];
      st_r.iso        <= uoec_pkg::CTL_HI_RST[uoec_pkg::HI_ISO];
      st_r.int_en     <= uoec_pkg::INT_EN_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A data end that the endpoint can store this cycle
  logic acc_ok;
  assign acc_ok = ce && rx.data_done && !st_r.stall_req && !full && !wr_lo;

  // Stall answer: token on a stalled endpoint, then flag and status
  sequence s_stall_hit;
    ce && rx.token && st_r.stall_req;
  endsequence

  sequence s_stall_answer;
    st_r.stall_hs && st_r.stall_sent && st_r.int_sts[uoec_pkg::INT_STL];
  endsequence

  AST_STALL_SET: assert property (s_stall_hit |=> s_stall_answer)  // [RULE1]
    else $error("stall not reported");

  // The handshake request lasts one cycle unless another stalled token follows
  AST_STALL_PULSE: assert property (  // [RULE7]
      ce && st_r.stall_hs && !(rx.token && st_r.stall_req) |=> !st_r.stall_hs)
    else $error("stall handshake held too long");

  // An enabled stall event raises the interrupt line on the next cycle
  AST_STALL_IRQ: assert property (  // [RULE1]
      ce && rx.token && st_r.stall_req && st_r.int_en[uoec_pkg::INT_STL] &&
      !(wr && idx == uoec_pkg::INT_EN_IDX) |=> irq)
    else $error("stall interrupt missing");

  // Only a firmware write of zero may drop the sent-stall flag
  AST_STALL_HOLD: assert property (ce && st_r.stall_sent &&  // [RULE2]
      !(wr_lo && !apb.pwdata[uoec_pkg::LO_STL_SENT]) |=> st_r.stall_sent)
    else $error("sent-stall flag cleared without firmware");

  // Buffer depth follows the double-buffer bit
  AST_SINGLE_BUF: assert property (ce && rx.data_done && !st_r.dbl &&  // [RULE3]
      st_r.pkts == 2'h1 && !wr_lo |=> st_r.pkts == 2'h1)
    else $error("single buffer took a second packet");
  AST_DBL_TAKE: assert property (ce && rx.data_done && st_r.dbl && !st_r.iso &&  // [RULE3]
      !rx.crc_err && !st_r.stall_req && st_r.pkts == 2'h1 && !wr_lo |=> st_r.pkts == 2'h2)
    else $error("double buffer refused a second packet");

  // Bulk drops a bad packet and never reports an overrun
  AST_BULK_CRC: assert property (  // [RULE4]
      acc_ok && !st_r.iso && rx.crc_err |=> $stable(st_r.pkts))
    else $error("bulk packet with bad crc stored");
  AST_BULK_NOOVR: assert property (ce && rx.data_done && !st_r.iso && full &&  // [RULE4]
      !wr_lo |=> $stable(st_r.overrun))
    else $error("bulk endpoint flagged an overrun");

  // Unused high bits and the write-only toggle clear read zero
  AST_HI_ZERO: assert property (ce && apb.psel && !apb.penable &&  // [RULE5]
      idx == uoec_pkg::CTL_HI_IDX |=> prdata[5:0] == 6'h00)
    else $error("high byte low bits not zero");
  AST_LO_TGL_RD: assert property (ce && apb.psel && !apb.penable &&  // [RULE10]
      idx == uoec_pkg::CTL_LO_IDX |=> prdata[7] == 1'b0)
    else $error("toggle-clear bit not read as zero");

  // Accepted packets are announced
  AST_BULK_RDY: assert property (acc_ok && !st_r.iso && !rx.crc_err |=>  // [RULE6]
      st_r.pkt_rdy && st_r.int_sts[uoec_pkg::INT_PKT] && st_r.pkts == $past(st_r.pkts) + 2'h1)
    else $error("bulk packet not announced");
  AST_ISO_RDY: assert property (acc_ok && st_r.iso |=>  // [RULE4]
      st_r.pkt_rdy && st_r.int_sts[uoec_pkg::INT_PKT])
    else $error("iso packet not announced");

  // A stalled endpoint takes no data
  AST_STALL_NODATA: assert property (ce && rx.data_done && st_r.stall_req &&  // [RULE7]
      !wr_lo |=> $stable(st_r.pkts))
    else $error("data taken while stalled");

  // Isochronous overrun and bad-CRC handling
  AST_ISO_OVR: assert property (ce && rx.data_done && st_r.iso && !st_r.stall_req &&  // [RULE8]
      full && !wr_lo |=> st_r.overrun && st_r.int_sts[uoec_pkg::INT_OVR] && $stable(st_r.pkts))
    else $error("iso overrun not flagged");
  AST_ISO_CRC: assert property (acc_ok && st_r.iso && rx.crc_err |=>  // [RULE9]
      st_r.crc_err && st_r.pkt_rdy && st_r.pkts == $past(st_r.pkts) + 2'h1)
    else $error("iso crc packet not stored");

  // Toggle clear wins unless a packet flips the toggle in the same cycle
  AST_TGL_CLR: assert property (  // [RULE10]
      wr_lo && apb.pwdata[uoec_pkg::LO_TGL_CLR] && !rx.data_done |=> !tx.toggle)
    else $error("toggle not cleared");
endmodule  // uoec_out_ep

// file: uoec_host.sv
`timescale 1ns/1ps
// Host side: token, one idle cycle, then data end
module uoec_host (
  input  wire logic          pclk,
  input  wire logic          go,
  input  wire logic          crc,
  output uoec_pkg::uoec_rx_t rx
);
  logic [1:0] st = 2'h0;
  logic       cq = 1'b0;
  logic       jk = 1'b0;
  // Steps 1 to 3 after a request; jk keeps crc from looking valid when idle
  always @(posedge pclk) begin
    jk <= ~jk;
    if (st != 2'h0 || go) st <= st + 2'h1;
    if (go) cq <= crc;
  end
  assign rx.token     = (st == 2'h1);
  assign rx.data_done = (st == 2'h3);
  assign rx.crc_err   = (st == 2'h3) ? cq : jk;
endmodule // uoec_host

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    go = 1'b0;
  logic                    serr;
  logic [31:0]             rd;
  int                      n_fail = 0;
  int                      n_compared = 0;
  int                      n_stl = 0;
  uoec_pkg::uoec_apb_req_t req = '0;
  uoec_pkg::uoec_rx_t      rx;
  uoec_pkg::uoec_tx_t      tx;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    crc = 1'b0;
  logic                    ce = 1'b1;

  uoec_out_ep u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx(rx), .tx(tx), .irq(irq));
  uoec_host u_host (.pclk(pclk), .go(go), .crc(crc), .rx(rx));

  // Clock, 100 ns period
  initial begin
    forever #50 pclk = ~pclk;
  end
  // Stall handshakes seen
  always @(posedge pclk) if (tx.stall_hs === 1'b1) n_stl <= n_stl + 1;

  task automatic results;
    $display("fails %0d compares %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then an idle cycle so psel is never assigned twice at one edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int i;
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= {idx, 2'h0};
    req.pwdata <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    serr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
    if (i >= 20) begin
      n_fail++;
      results();
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // The host model's frame lasts four edges
  task automatic pkt(input logic c);
    go <= 1'b1;
    crc <= c;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic s_reset;
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    rchk(uoec_pkg::CTL_HI_IDX, 32'h0);
    rchk(uoec_pkg::INT_EN_IDX, 32'h0);
    chk(tx.room, 1'b1);
  endtask
  task automatic s_hi;
    wr(uoec_pkg::CTL_HI_IDX, 32'hffffffff);
    rchk(uoec_pkg::CTL_HI_IDX, 32'hc0);
    wr(uoec_pkg::CTL_HI_IDX, 32'h0);
  endtask
  // Single buffer: second packet refused while one is held
  task automatic s_bulk;
    pkt(1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h03);
    chk(tx.room, 1'b0);
    chk(irq, 1'b0);
    pkt(1'b0);
    chk(tx.toggle, 1'b1);
    rchk(uoec_pkg::INT_STS_IDX, 32'h1);
    wr(uoec_pkg::INT_EN_IDX, 32'h1);
    chk(irq, 1'b1);
    wr(uoec_pkg::CTL_LO_IDX, 32'h0);
    wr(uoec_pkg::INT_CLR_IDX, 32'h7);
    chk(irq, 1'b0);
  endtask
  task automatic s_dbl;
    wr(uoec_pkg::CTL_HI_IDX, 32'h80);
    pkt(1'b0);
    chk(tx.room, 1'b1);
    pkt(1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h03);
    wr(uoec_pkg::INT_CLR_IDX, 32'h7);
    wr(uoec_pkg::CTL_LO_IDX, 32'h0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h01);
    rchk(uoec_pkg::INT_STS_IDX, 32'h1);
    wr(uoec_pkg::CTL_LO_IDX, 32'h0);
    chk(tx.toggle, 1'b1);
    wr(uoec_pkg::CTL_LO_IDX, 32'h80);
    chk(tx.toggle, 1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    wr(uoec_pkg::CTL_HI_IDX, 32'h0);
  endtask
  task automatic s_stall;
    int k;
    wr(uoec_pkg::INT_CLR_IDX, 32'h7);
    wr(uoec_pkg::INT_EN_IDX, 32'h2);
    wr(uoec_pkg::CTL_LO_IDX, 32'h20);
    k = n_stl;
    pkt(1'b0);
    chk(32'(n_stl - k), 32'h1);
    pkt(1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h60);
    chk(irq, 1'b1);
    wr(uoec_pkg::CTL_LO_IDX, 32'h20);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h20);
    wr(uoec_pkg::CTL_LO_IDX, 32'h0);
    wr(uoec_pkg::INT_CLR_IDX, 32'h7);
  endtask
  task automatic s_iso;
    wr(uoec_pkg::CTL_HI_IDX, 32'h40);
    wr(uoec_pkg::INT_EN_IDX, 32'h4);
    pkt(1'b1);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0b);
    pkt(1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0f);
    rchk(uoec_pkg::INT_STS_IDX, 32'h5);
    chk(irq, 1'b1);
    wr(uoec_pkg::CTL_LO_IDX, 32'h0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    apb(1'b0, 10'h3ff, 32'h0);
    chk(serr, 1'b1);
    chk(rd, 32'h0);
  endtask
  // Bulk CRC drop, clock-enable freeze, flush and a reset in mid-run
  task automatic s_misc;
    wr(uoec_pkg::CTL_HI_IDX, 32'h0);
    pkt(1'b1);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    chk(tx.toggle, 1'b0);
    ce <= 1'b0;
    @(posedge pclk);
    chk(pready, 1'b0);
    pkt(1'b0);
    ce <= 1'b1;
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    pkt(1'b0);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h03);
    wr(uoec_pkg::CTL_LO_IDX, 32'h11);
    rchk(uoec_pkg::CTL_LO_IDX, 32'h0);
    wr(uoec_pkg::INT_EN_IDX, 32'h7);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(uoec_pkg::INT_EN_IDX, 32'h0);
    rchk(uoec_pkg::INT_STS_IDX, 32'h0);
    chk(irq, 1'b0);
  endtask

  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_hi();
    s_bulk();
    s_dbl();
    s_stall();
    s_iso();
    s_misc();
    results();
  end
endmodule // tb_top
